//--- hdl/lrrp_ram.sv
`timescale 1ns/100ps
module lrrp_ram (
    input  wire logic core_clk,
    input  wire logic rst_b,
    lrrp_ram_if.mem   ramBus
);
    import lrrp_pkg::*;

    logic [DATA_W-1:0] mem [PAGES][COLS];
    logic [DATA_W-1:0] rdata_q;
    logic              inRange;

    // Column may sit on the stop address, which has no storage
    assign inRange = (ramBus.col < COL_STOP);

    always_ff @(posedge core_clk)
    begin
        if (ramBus.wrEn && inRange)
        begin
            mem[ramBus.page][ramBus.col] <= ramBus.wdata;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rdata_q <= '0;
        end
        else
        begin
            rdata_q <= inRange ? mem[ramBus.page][ramBus.col] : '0;
        end
    end

    assign ramBus.rdata = rdata_q;
endmodule : lrrp_ram

//--- hdl/lrrp_sync.sv
`timescale 1ns/100ps
module lrrp_sync #(
    parameter int               WIDTH = 1,
    parameter logic [WIDTH-1:0] IDLE  = '0
) (
    input  wire logic             core_clk,
    input  wire logic             rst_b,
    input  wire logic [WIDTH-1:0] pinIn,
    output logic      [WIDTH-1:0] pinOut
);
    // A bit changes only once stages two and three agree
    for (genvar i = 0; i < WIDTH; i++)
    begin : g_bit
        logic [2:0] shift_q;
        logic       out_q;
        always_ff @(posedge core_clk or negedge rst_b)
        begin
            if (!rst_b)
            begin
                shift_q <= {3{IDLE[i]}};
                out_q   <= IDLE[i];
            end
            else
            begin
                shift_q <= {shift_q[1:0], pinIn[i]};
                if (shift_q[1] == shift_q[2])
                begin
                    out_q <= shift_q[2];
                end
            end
        end
        assign pinOut[i] = out_q;
    end
endmodule : lrrp_sync

//--- hdl/lrrp_top.sv
`timescale 1ns/100ps
module lrrp_top #(
    parameter int RESET_CYCLES = lrrp_pkg::RESET_CYC
) (
    input  wire logic                        core_clk,
    input  wire logic                        rst_b,
    input  wire logic                        hwResetNPin,
    input  wire logic                        hostWrN,
    input  wire logic                        hostRdN,
    input  wire logic                        cmdDataSelect,
    input  wire logic [lrrp_pkg::DATA_W-1:0] hostDataBusIn,
    input  wire logic                        extOscIn,
    input  wire logic                        adcNormal,
    output logic      [lrrp_pkg::DATA_W-1:0] hostDataBusOut,
    output logic                             hostDataBusOe,
    output logic      [lrrp_pkg::COL_W-1:0]  colAddr,
    output logic      [lrrp_pkg::PAGE_W-1:0] pageAddr,
    output logic      [lrrp_pkg::LINE_W-1:0] startLine,
    output logic                             displayOn,
    output logic                             staticDrive,
    output logic                             rmwActive,
    output logic                             powerSave,
    output logic                             scanEnable,
    output logic                             driversToVdd,
    output logic                             oscOutPin,
    output logic                             oscOutOe,
    output logic                             busy
);
    import lrrp_pkg::*;

    if (RESET_CYCLES < 1 || RESET_CYCLES >= (1 << RST_CNT_W))
    begin : g_bad_reset
        $error("RESET_CYCLES out of counter range");
    end

    // ------------------------------------------------------------
    // Pin conditioning
    // ------------------------------------------------------------
    logic [PIN_W-1:0]  pinFilt;
    logic              oscF;
    logic              hwRstNF;
    logic              wrNF;
    logic              rdNF;
    logic              a0F;
    logic [DATA_W-1:0] dataF;

    lrrp_sync #(
        .WIDTH (PIN_W),
        .IDLE  (PIN_IDLE)
    ) u_sync (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .pinIn    ({extOscIn, hwResetNPin, hostWrN, hostRdN, cmdDataSelect, hostDataBusIn}),
        .pinOut   (pinFilt)
    );

    assign {oscF, hwRstNF, wrNF, rdNF, a0F, dataF} = pinFilt;

    // ------------------------------------------------------------
    // Strobe edges and access decode
    // ------------------------------------------------------------
    logic           wrNPrev_q;
    logic           rdNPrev_q;
    lrrp_state_type state_q;
    logic [RST_CNT_W-1:0] rstCnt_q;
    logic           busyNow;
    logic           wrDone;
    logic           rdStart;
    logic           rdDone;
    logic           cmdWr;
    logic           dataWr;
    logic           dataRd;

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wrNPrev_q <= 1'b1;
            rdNPrev_q <= 1'b1;
        end
        else
        begin
            wrNPrev_q <= wrNF;
            rdNPrev_q <= rdNF;
        end
    end

    // Write is taken at the trailing edge, when the data has settled
    assign busyNow = (state_q == ST_RESET);
    assign wrDone  = wrNF & ~wrNPrev_q;
    assign rdStart = ~rdNF & rdNPrev_q;
    assign rdDone  = rdNF & ~rdNPrev_q;
    assign cmdWr   = wrDone & ~a0F & ~busyNow;                           // R16
    assign dataWr  = wrDone & a0F & ~busyNow;
    assign dataRd  = rdDone & a0F & ~busyNow;

    // ------------------------------------------------------------
    // Reset sequencer
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q  <= ST_RUN;
            rstCnt_q <= '0;
        end
        else if (!hwRstNF || (cmdWr && dataF == CMD_RESET))
        begin
            state_q  <= ST_RESET;                                        // R16
            rstCnt_q <= RST_CNT_W'(RESET_CYCLES);
        end
        else
        begin
            case (state_q)
                ST_RUN:
                begin
                    state_q <= ST_RUN;
                end
                ST_RESET:
                begin
                    rstCnt_q <= rstCnt_q - CNT_LAST;
                    if (rstCnt_q == CNT_LAST)
                    begin
                        state_q <= ST_RUN;
                    end
                end
                default:
                begin
                    state_q <= ST_RUN;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Address and scroll registers
    // ------------------------------------------------------------
    logic [LINE_W-1:0] startLine_q;
    logic [PAGE_W-1:0] page_q;
    logic [COL_W-1:0]  col_q;
    logic [COL_W-1:0]  savedCol_q;
    logic              rmw_q;

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            startLine_q <= LINE_RESET;
            page_q      <= PAGE_RESET;
        end
        else if (!hwRstNF || (cmdWr && dataF == CMD_RESET))
        begin
            startLine_q <= LINE_RESET;                                   // R6
            page_q      <= PAGE_RESET;                                   // R6
        end
        else if (cmdWr && (dataF & MASK_LINE) == CMD_LINE)
        begin
            startLine_q <= dataF[LINE_W-1:0];
        end
        else if (cmdWr && (dataF & MASK_PAGE) == CMD_PAGE)
        begin
            page_q <= dataF[PAGE_W-1:0];
        end
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rmw_q      <= 1'b0;
            savedCol_q <= COL_RESET;
        end
        else if (!hwRstNF)
        begin
            rmw_q <= 1'b0;
        end
        else if (cmdWr && dataF == CMD_RMW)
        begin
            rmw_q      <= 1'b1;                                          // R1
            savedCol_q <= col_q;                                         // R1
        end
        else if (cmdWr && dataF == CMD_END)
        begin
            rmw_q <= 1'b0;                                               // R3 R4
        end
    end

    // Column stops at the stop address rather than wrapping to the next page
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            col_q <= COL_RESET;
        end
        else if (!hwRstNF)
        begin
            col_q <= COL_RESET;
        end
        else if (cmdWr && dataF == CMD_END && rmw_q)
        begin
            col_q <= savedCol_q;                                         // R4
        end
        else if (cmdWr && (dataF & MASK_COL) == CMD_COL)
        begin
            col_q <= dataF[COL_W-1:0];
        end
        else if ((dataWr || (dataRd && !rmw_q)) && col_q < COL_STOP)
        begin
            col_q <= col_q + COL_ONE;                                    // R2 R14 R17
        end
    end

    // ------------------------------------------------------------
    // Display memory and read latch
    // ------------------------------------------------------------
    lrrp_ram_if        ramBus ();
    logic [DATA_W-1:0] latch_q;

    // Only data writes reach the array; the reset paths never do
    assign ramBus.wrEn  = dataWr;                                        // R7 R14
    assign ramBus.page  = page_q;
    assign ramBus.col   = col_q;
    assign ramBus.wdata = dataF;

    lrrp_ram u_ram (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .ramBus   (ramBus.mem)
    );

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            latch_q <= '0;
        end
        else if (dataRd)
        begin
            latch_q <= ramBus.rdata;                                     // R15
        end
    end

    // ------------------------------------------------------------
    // Display flags and power-save
    // ------------------------------------------------------------
    logic displayOn_d;
    logic staticDrive_d;
    logic displayOn_q;
    logic staticDrive_q;
    logic psave_q;

    always_comb
    begin
        displayOn_d   = displayOn_q;
        staticDrive_d = staticDrive_q;
        if (!hwRstNF)
        begin
            displayOn_d   = 1'b0;
            staticDrive_d = 1'b0;
        end
        else if (cmdWr && (dataF & MASK_FLAG) == CMD_DISP)
        begin
            displayOn_d = dataF[0];
        end
        else if (cmdWr && (dataF & MASK_FLAG) == CMD_STATIC)
        begin
            staticDrive_d = dataF[0];
        end
    end

    // Power-save has no command of its own; it tracks the two flags
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            displayOn_q   <= 1'b0;
            staticDrive_q <= 1'b0;
            psave_q       <= 1'b0;
        end
        else
        begin
            displayOn_q   <= displayOn_d;
            staticDrive_q <= staticDrive_d;
            psave_q       <= staticDrive_d & ~displayOn_d;               // R9 R13 R18
        end
    end

    // Outputs lag the mode by one cycle; the drivers settle far slower
    logic scan_q;
    logic vdd_q;
    logic osc_q;
    logic oscOe_q;

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            scan_q  <= 1'b1;
            vdd_q   <= 1'b0;
            osc_q   <= 1'b0;
            oscOe_q <= 1'b1;
        end
        else
        begin
            scan_q  <= ~psave_q;                                         // R10
            vdd_q   <= psave_q;                                          // R10
            osc_q   <= oscF & ~psave_q;                                  // R11
            oscOe_q <= ~psave_q;                                         // R11
        end
    end

    // ------------------------------------------------------------
    // Host read path
    // ------------------------------------------------------------
    logic [DATA_W-1:0] statusByte;
    logic [DATA_W-1:0] rdOut_q;
    logic              rdOe_q;

    always_comb
    begin
        statusByte               = '0;
        statusByte[ST_BUSY_BIT]  = busyNow;                              // R16
        statusByte[ST_ADC_BIT]   = adcNormal;
        statusByte[ST_ONOFF_BIT] = ~displayOn_q;
        statusByte[ST_RESET_BIT] = busyNow;                              // R16
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rdOut_q <= '0;
            rdOe_q  <= 1'b0;
        end
        else if (rdStart)
        begin
            rdOut_q <= a0F ? latch_q : statusByte;                       // R15
            rdOe_q  <= 1'b1;
        end
        else if (rdDone)
        begin
            rdOe_q <= 1'b0;
        end
    end

    assign hostDataBusOut = rdOut_q;
    assign hostDataBusOe  = rdOe_q;
    assign colAddr        = col_q;
    assign pageAddr       = page_q;
    assign startLine      = startLine_q;
    assign displayOn      = displayOn_q;
    assign staticDrive    = staticDrive_q;
    assign rmwActive      = rmw_q;
    assign powerSave      = psave_q;
    assign scanEnable     = scan_q;
    assign driversToVdd   = vdd_q;
    assign oscOutPin      = osc_q;
    assign oscOutOe       = oscOe_q;
    assign busy           = state_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    sequence sqRmwEnter;
        cmdWr && dataF == CMD_RMW;
    endsequence

    sequence sqEndCmd;
        cmdWr && dataF == CMD_END && rmw_q;
    endsequence

    sequence sqSoftReset;
        cmdWr && dataF == CMD_RESET && hwRstNF;
    endsequence

    sequence sqStaticOn;
        cmdWr && hwRstNF && dataF == (CMD_STATIC | 8'h01) && !displayOn_q;
    endsequence

    a_rmw_save_col: assert property (sqRmwEnter |=> rmw_q && savedCol_q == $past(col_q)) // R1
        else $error("RMW entry did not save column");
    a_rmw_read_hold: assert property (dataRd && rmw_q |=> col_q == $past(col_q)) // R2
        else $error("Column moved on RMW read");
    a_rmw_stays: assert property (rmw_q && hwRstNF && !(cmdWr && dataF == CMD_END) |=> rmw_q) // R3
        else $error("RMW mode dropped early");
    a_end_restore: assert property (sqEndCmd |=> !rmw_q && col_q == $past(savedCol_q)) // R4
        else $error("End did not restore column");
    a_soft_reset_regs: assert property (sqSoftReset |=> startLine_q == LINE_RESET
        && page_q == PAGE_RESET && busyNow ##1 busyNow) // R6
        else $error("Reset command result wrong");
    a_reset_no_wr: assert property (busyNow |-> !ramBus.wrEn) // R7
        else $error("Memory written during reset");
    a_psave_flags: assert property (sqStaticOn |=> psave_q) // R9
        else $error("Power-save not entered on static drive");
    a_psave_drive: assert property (psave_q |=> !scan_q && vdd_q && !oscOe_q && !osc_q) // R10
        else $error("Power-save outputs wrong");
    a_psave_keep: assert property (psave_q && !cmdWr && hwRstNF |=> $stable(startLine_q)
        && $stable(page_q) && $stable(rmw_q)) // R12
        else $error("Setting lost in power-save");
    a_psave_exit: assert property (psave_q && cmdWr && dataF == (CMD_DISP | 8'h01)
        |=> !psave_q ##1 scan_q) // R13
        else $error("Power-save not left on display on");
    a_write_inc: assert property (dataWr && col_q < COL_STOP |=> col_q == $past(col_q)
        + COL_ONE) // R14
        else $error("Write did not increment column");
    a_read_refill: assert property (dataRd |=> latch_q == $past(ramBus.rdata)) // R15
        else $error("Latch not refilled from memory");
    a_busy_blocks: assert property (busyNow && wrDone |=> $stable(col_q) && $stable(rmw_q)) // R16
        else $error("Command taken while busy");
    a_rmw_write_inc: assert property (dataWr && rmw_q && col_q < COL_STOP |=> col_q != $past(col_q)) // R17
        else $error("RMW write did not increment");

endmodule : lrrp_top

//--- shared/lrrp_pkg.sv
// Operation
// R1: RMW command saves column, enters RMW mode
// R2: Data reads in RMW keep column
// R3: RMW mode persists until End command
// R4: End restores saved column, leaves RMW
// R5: Host avoids column set during RMW
// R6: Reset command clears start line, page 3
// R7: Reset command leaves display memory intact
// R8: Host must pulse reset pin at power-up
// R9: Static on with display off selects power-save
// R10: Power-save stops scan, drivers to VDD
// R11: Power-save ignores clock, floats oscillator out
// R12: Power-save keeps all settings
// R13: Display on or static off leaves power-save
// R14: Data write stores byte, increments column
// R15: Read returns latch, refills before increment
// R16: Reset shows reset and busy, blocks commands
// R17: Writes in RMW still increment column
// R18: Power-save follows stored flags at write
package lrrp_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int DATA_W    = 8;
    localparam int COL_W     = 7;
    localparam int PAGE_W    = 2;
    localparam int LINE_W    = 5;
    localparam int PAGES     = 4;
    localparam int COLS      = 80;
    localparam int PIN_W     = 13;
    localparam int RST_CNT_W = 8;

    // ------------------------------------------------------------
    // Command bytes and decode masks
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_RMW       = 8'hE0;
    localparam logic [7:0] CMD_END       = 8'hEE;
    localparam logic [7:0] CMD_RESET     = 8'hE2;
    localparam logic [7:0] CMD_DISP      = 8'hAE;
    localparam logic [7:0] CMD_STATIC    = 8'hA4;
    localparam logic [7:0] MASK_FLAG     = 8'hFE;
    localparam logic [7:0] CMD_LINE      = 8'hC0;
    localparam logic [7:0] MASK_LINE     = 8'hE0;
    localparam logic [7:0] CMD_PAGE      = 8'hB8;
    localparam logic [7:0] MASK_PAGE     = 8'hFC;
    localparam logic [7:0] CMD_COL       = 8'h00;
    localparam logic [7:0] MASK_COL      = 8'h80;

    // ------------------------------------------------------------
    // Reset values and limits
    // ------------------------------------------------------------
    localparam logic [COL_W-1:0]  COL_RESET  = 7'h00;
    localparam logic [COL_W-1:0]  COL_STOP   = 7'h50;
    localparam logic [COL_W-1:0]  COL_ONE    = 7'h01;
    localparam logic [PAGE_W-1:0] PAGE_RESET = 2'h3;
    localparam logic [LINE_W-1:0] LINE_RESET = 5'h00;
    localparam logic [PIN_W-1:0]  PIN_IDLE   = 13'h0E00;

    // ------------------------------------------------------------
    // Status byte layout
    // ------------------------------------------------------------
    localparam int ST_BUSY_BIT  = 7;
    localparam int ST_ADC_BIT   = 6;
    localparam int ST_ONOFF_BIT = 5;
    localparam int ST_RESET_BIT = 4;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int RESET_TIME_NS = 1000;
    localparam int RESET_CYC     = (RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [RST_CNT_W-1:0] CNT_LAST = 8'h01;

    typedef enum logic [0:0] {
        ST_RUN   = 1'b0,
        ST_RESET = 1'b1
    } lrrp_state_type;

endpackage : lrrp_pkg

//--- shared/lrrp_ram_if.sv
`timescale 1ns/100ps
interface lrrp_ram_if;
    logic                         wrEn;
    logic [lrrp_pkg::PAGE_W-1:0]  page;
    logic [lrrp_pkg::COL_W-1:0]   col;
    logic [lrrp_pkg::DATA_W-1:0]  wdata;
    logic [lrrp_pkg::DATA_W-1:0]  rdata;

    modport ctrl (output wrEn, output page, output col, output wdata, input rdata);
    modport mem  (input wrEn, input page, input col, input wdata, output rdata);
endinterface : lrrp_ram_if

//--- tb/lcd_rmw_reset_powersave_test.sv
`timescale 1ns/100ps
module lcd_rmw_reset_powersave_test;
    import lrrp_pkg::*;
    localparam int RST_N = 40;
    logic       core_clk, rst_b, hwResetNPin, hostWrN, hostRdN, cmdDataSelect, extOscIn;
    logic       adcNormal, hostDataBusOe, displayOn, staticDrive, rmwActive, powerSave;
    logic       scanEnable, driversToVdd, oscOutPin, oscOutOe, busy;
    logic [7:0] hostDataBusIn, hostDataBusOut;
    logic [6:0] colAddr;
    logic [1:0] pageAddr;
    logic [4:0] startLine;
    logic [8:0] q;
    logic [7:0] psSeq [4] = '{8'hA5, 8'hAF, 8'hAE, 8'hA4};
    int         errCount, cmpCount, cycles, seed, mCol, mPage, mLine, mSave, mLatch;
    int         mem [4][80];
    bit         mRmw, mDisp, mStat, mPs;

    lrrp_top #(.RESET_CYCLES(RST_N)) dut (.core_clk(core_clk), .rst_b(rst_b),
        .hwResetNPin(hwResetNPin), .hostWrN(hostWrN), .hostRdN(hostRdN),
        .cmdDataSelect(cmdDataSelect), .hostDataBusIn(hostDataBusIn), .extOscIn(extOscIn),
        .adcNormal(adcNormal), .hostDataBusOut(hostDataBusOut), .hostDataBusOe(hostDataBusOe),
        .colAddr(colAddr), .pageAddr(pageAddr), .startLine(startLine), .displayOn(displayOn),
        .staticDrive(staticDrive), .rmwActive(rmwActive), .powerSave(powerSave),
        .scanEnable(scanEnable), .driversToVdd(driversToVdd), .oscOutPin(oscOutPin),
        .oscOutOe(oscOutOe), .busy(busy));
    lrrp_host host (.core_clk(core_clk), .dIn(hostDataBusOut), .dOe(hostDataBusOe),
        .wrN(hostWrN), .rdN(hostRdN), .sel(cmdDataSelect), .dOut(hostDataBusIn));

    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    always @(posedge core_clk)
    begin
        extOscIn <= #1 1'(($random(seed)));
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            errCount++;
            testDone();
        end
    end

    task automatic testDone;
        if (errCount == 0 && cmpCount > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : testDone

    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        cmpCount++;
        if (seen !== exp)
        begin
            errCount++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic chkRegs;
        chk(9'(colAddr), 9'(mCol));
        chk(9'(pageAddr), 9'(mPage));
        chk(9'(startLine), 9'(mLine));
        chk(9'(rmwActive), 9'(mRmw));
        chk(9'(powerSave), 9'(mStat && !mDisp));
        chk(9'({displayOn, staticDrive}), 9'({mDisp, mStat}));
    endtask : chkRegs

    task automatic waitIdle;
        for (int i = 0; i < 200 && busy !== 1'b0; i++) @(posedge core_clk);
        chk(9'(busy), 9'h000);
    endtask : waitIdle

    task automatic cmd(input logic [7:0] b);
        host.wr(1'b0, b);
        if (b == CMD_RMW)
        begin
            mRmw = 1;
            mSave = mCol;
        end
        else if (b == CMD_END && mRmw)
        begin
            mRmw = 0;
            mCol = mSave;
        end
        else if (b == CMD_RESET)
        begin
            mLine = 0;
            mPage = 3;
        end
        else if ((b & MASK_FLAG) == CMD_DISP) mDisp = b[0];
        else if ((b & MASK_FLAG) == CMD_STATIC) mStat = b[0];
        else if ((b & MASK_LINE) == CMD_LINE) mLine = b[4:0];
        else if ((b & MASK_PAGE) == CMD_PAGE) mPage = b[1:0];
        else if ((b & MASK_COL) == CMD_COL) mCol = b[6:0];
    endtask : cmd

    task automatic dwr;
        logic [7:0] d;
        d = 8'($random(seed));
        host.wr(1'b1, d);
        if (mCol < 80) mem[mPage][mCol] = d;
        if (mCol < 80) mCol++;
        chkRegs();
    endtask : dwr

    // Latch content is only compared once it came from a written location or the stop address
    task automatic drd;
        host.rd(1'b1, q);
        if (mLatch >= 0) chk(q, {1'b1, 8'(mLatch)});
        mLatch = (mCol < 80) ? mem[mPage][mCol] : 0;
        if (!mRmw && mCol < 80) mCol++;
        chkRegs();
    endtask : drd

    initial
    begin
        seed = 32'h1968f731;
        {errCount, cmpCount, cycles, mCol, mLine, mRmw, mDisp, mStat} = '0;
        mPage = 3;
        mLatch = -1;
        foreach (mem[p, c]) mem[p][c] = -1;
        rst_b = 1'b0;
        hwResetNPin = 1'b0;
        adcNormal = 1'b1;
        repeat (4) @(posedge core_clk);
        #1;
        rst_b = 1'b1;
        repeat (8) @(posedge core_clk);
        #1;
        hwResetNPin = 1'b1;
        waitIdle();
        chkRegs();
        // ------------------------------------------------------------
        // Writes up to and past the last column
        // ------------------------------------------------------------
        cmd(CMD_PAGE | 8'h01);
        cmd(8'h4C);
        repeat (6) dwr();
        cmd(8'h02);
        drd();
        // ------------------------------------------------------------
        // Read-modify-write with a soft reset inside; no column set here
        // ------------------------------------------------------------
        cmd(CMD_RMW);
        chkRegs();
        repeat (3)
        begin
            drd();
            dwr();
        end
        cmd(CMD_LINE | 8'(($random(seed)) & 31));
        adcNormal = 1'(($random(seed)));
        cmd(CMD_RESET);
        host.rd(1'b0, q);
        chk(q, {1'b1, 1'b1, adcNormal, !mDisp, 1'b1, 4'h0});
        // Still busy: this End must be ignored, so RMW stays on
        host.wr(1'b0, CMD_END);
        waitIdle();
        chkRegs();
        cmd(CMD_END);
        chkRegs();
        // Memory written before the soft reset must read back intact
        cmd(CMD_PAGE | 8'h01);
        cmd(8'h02);
        repeat (5) drd();
        // ------------------------------------------------------------
        // Power-save entry and both exits
        // ------------------------------------------------------------
        foreach (psSeq[i])
        begin
            cmd(psSeq[i]);
            mPs = mStat && !mDisp;
            chkRegs();
            chk(9'({scanEnable, driversToVdd}), 9'({!mPs, mPs}));
            chk(9'(oscOutOe), 9'(!mPs));
            repeat (4)
            begin
                @(posedge core_clk);
                if (mPs) chk(9'(oscOutPin), 9'h000);
            end
        end
        testDone();
    end
endmodule : lcd_rmw_reset_powersave_test

//--- tb/lrrp_host.sv
`timescale 1ns/100ps
module lrrp_host (
    input  wire logic       core_clk,
    input  wire logic [7:0] dIn,
    input  wire logic       dOe,
    output logic            wrN,
    output logic            rdN,
    output logic            sel,
    output logic [7:0]      dOut
);
    // Six cycles each side keeps every strobe well clear of the 4-cycle pin filter
    localparam int HOLD = 6;

    initial
    begin
        wrN = 1'b1;
        rdN = 1'b1;
        sel = 1'b0;
        dOut = 8'h00;
    end

    task automatic wr(input logic s, input logic [7:0] d);
        @(posedge core_clk);
        #1;
        sel = s;
        dOut = d;
        wrN = 1'b0;
        repeat (HOLD) @(posedge core_clk);
        #1;
        wrN = 1'b1;
        // Data held past the filtered rising edge, then released to a changed value
        repeat (HOLD) @(posedge core_clk);
        #1;
        dOut = ~d;
    endtask : wr

    task automatic rd(input logic s, output logic [8:0] q);
        @(posedge core_clk);
        #1;
        sel = s;
        rdN = 1'b0;
        repeat (HOLD) @(posedge core_clk);
        q = {dOe, dIn};
        #1;
        rdN = 1'b1;
        repeat (HOLD) @(posedge core_clk);
    endtask : rd
endmodule : lrrp_host
